/* common/rst_src_defines.svh */
`ifndef RST_SRC_DEFINES_SVH
`define RST_SRC_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------
`define IDX_CAUSE_STATUS 8'h01
`define IDX_FILTER_CTRL 8'h04
`define IDX_FILTER_WIDTH 8'h05
`define IDX_IRQ_STATUS 8'h08
`define IDX_IRQ_MASK 8'h09

// ----------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------
`define BIT_STOP_ACK 5
`define BIT_DEBUGGER 3
`define BIT_SOFTWARE 2
`define BIT_LOCKUP 1
`define BIT_PIN_EVENT 6
`define BIT_STOP_SEL 2
`define RW_SEL_HI 1
`define RW_SEL_LO 0
`define WIDTH_SEL_HI 4

// ----------------------------------------------------------------
// Field codes and reset values.
// ----------------------------------------------------------------
`define RW_SEL_OFF 2'h0
`define RW_SEL_BUS 2'h1
`define RW_SEL_LPO 2'h2
`define CAUSE_RST 8'h00
`define CTRL_RST 3'h0
`define WIDTH_RST 5'h00
`define IRQ_RST 8'h00
`define CAUSE_MASK 8'h2e
`define IRQ_MASK_BITS 8'h6e
`define LPO_FILTER_COUNT 3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* common/rst_src_pkg.sv */
package rst_src_pkg;

  typedef enum logic [2:0] {
    sel_cause,
    sel_ctrl,
    sel_width,
    sel_irq,
    sel_mask,
    sel_none
  } reg_sel_e;

endpackage

/* hw/reset_source_status_and_pin_filter.sv */
`timescale 1ns/1ns
`include "rst_src_defines.svh"
module reset_source_status_and_pin_filter #(
  parameter int ADDR_W = 8,
  parameter int LPO_COUNT = `LPO_FILTER_COUNT
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_chip_por,
  input wire logic i_low_voltage_detect,
  input wire logic i_very_low_leakage_stop_wakeup,
  input wire logic i_stop_ack_timeout,
  input wire logic i_debugger_reset_req,
  input wire logic i_core_system_reset_request,
  input wire logic i_core_lockup,
  input wire logic i_stop_mode,
  input wire logic i_reset_pin_n,
  input wire logic i_low_power_oscillator_clock,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic o_pin_reset,
  output logic o_reset_req,
  output logic o_irq
);

  generate
    if (ADDR_W < 8 || LPO_COUNT < 1 || LPO_COUNT > 63) begin : g_bad
      $error("reset_source_status_and_pin_filter: bad parameter");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Address decode.
  // ----------------------------------------------------------------
  function automatic rst_src_pkg::reg_sel_e reg_sel(
    input logic [ADDR_W-1:0] addr
  );
    logic [ADDR_W-1:0] idx;
    idx = addr >> 2;
    if (addr[1:0] != 2'h0) begin
      reg_sel = rst_src_pkg::sel_none;
    end else if (idx == ADDR_W'(`IDX_CAUSE_STATUS)) begin
      reg_sel = rst_src_pkg::sel_cause;
    end else if (idx == ADDR_W'(`IDX_FILTER_CTRL)) begin
      reg_sel = rst_src_pkg::sel_ctrl;
    end else if (idx == ADDR_W'(`IDX_FILTER_WIDTH)) begin
      reg_sel = rst_src_pkg::sel_width;
    end else if (idx == ADDR_W'(`IDX_IRQ_STATUS)) begin
      reg_sel = rst_src_pkg::sel_irq;
    end else if (idx == ADDR_W'(`IDX_IRQ_MASK)) begin
      reg_sel = rst_src_pkg::sel_mask;
    end else begin
      reg_sel = rst_src_pkg::sel_none;
    end
  endfunction

  logic [7:0] cause_status;
  logic [2:0] filter_ctrl;
  logic [4:0] filter_width;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // ----------------------------------------------------------------
  // Register bus slave.
  // ----------------------------------------------------------------
  // Address and data may arrive in either order; each is held until the
  // other one is there, so a write is done in one place only.
  wire aw_take = i_awvalid & o_awready;
  wire w_take = i_wvalid & o_wready;
  wire aw_have = aw_held | aw_take;
  wire w_have = w_held | w_take;
  wire do_write = aw_have & w_have;
  wire [ADDR_W-1:0] wr_addr = aw_held ? aw_addr : i_awaddr;
  wire [31:0] wr_data = w_held ? w_data : i_wdata;
  wire [3:0] wr_strb = w_held ? w_strb : i_wstrb;
  wire rst_src_pkg::reg_sel_e wr_sel = reg_sel(wr_addr);
  wire wr_lane0 = do_write & wr_strb[0];
  wire wr_ctrl = wr_lane0 & (wr_sel == rst_src_pkg::sel_ctrl);
  wire wr_width = wr_lane0 & (wr_sel == rst_src_pkg::sel_width);
  wire wr_mask = wr_lane0 & (wr_sel == rst_src_pkg::sel_mask);
  wire wr_bad = wr_sel == rst_src_pkg::sel_none;

  wire rd_take = i_arvalid & o_arready;
  wire rst_src_pkg::reg_sel_e rd_sel = reg_sel(i_araddr);
  wire rd_irq = rd_take & (rd_sel == rst_src_pkg::sel_irq);
  wire [7:0] rd_byte =
    (rd_sel == rst_src_pkg::sel_cause) ? cause_status :
    (rd_sel == rst_src_pkg::sel_ctrl) ? {5'h00, filter_ctrl} :
    (rd_sel == rst_src_pkg::sel_width) ? {3'h0, filter_width} :
    (rd_sel == rst_src_pkg::sel_irq) ? irq_status :
    (rd_sel == rst_src_pkg::sel_mask) ? irq_mask : 8'h00;

  assign o_awready = ~aw_held & ~o_bvalid;
  assign o_wready = ~w_held & ~o_bvalid;
  assign o_arready = ~o_rvalid;

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= `RESP_OKAY;
    end else begin
      aw_held <= aw_have & ~do_write;
      w_held <= w_have & ~do_write;
      if (aw_take) begin
        aw_addr <= i_awaddr;
      end
      if (w_take) begin
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      if (do_write) begin
        o_bvalid <= 1'b1;
        o_bresp <= wr_bad ? `RESP_SLVERR : `RESP_OKAY;
      end else if (i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `RESP_OKAY;
    end else if (rd_take) begin
      o_rvalid <= 1'b1;
      o_rdata <= {24'h00_0000, rd_byte};
      o_rresp <= (rd_sel == rst_src_pkg::sel_none) ?
        `RESP_SLVERR : `RESP_OKAY;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Power-on-only configuration.
  // ----------------------------------------------------------------
  // These survive system resets so that the pin filter keeps guarding
  // the device while it recovers from one.
  always_ff @(posedge i_clk_sys or posedge i_chip_por) begin
    if (i_chip_por) begin
      filter_ctrl <= `CTRL_RST;
      filter_width <= `WIDTH_RST;
    end else begin
      if (wr_ctrl) begin
        filter_ctrl <= wr_data[`BIT_STOP_SEL:0];
      end
      if (wr_width) begin
        filter_width <= wr_data[`WIDTH_SEL_HI:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin and oscillator synchronisers.
  // ----------------------------------------------------------------
  logic [2:0] pin_sync;
  logic [2:0] lpo_sync;
  logic pin_level_n;
  logic lpo_level;
  logic lpo_level_d;

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_sync <= 3'h7;
      lpo_sync <= 3'h0;
      pin_level_n <= 1'b1;
      lpo_level <= 1'b0;
      lpo_level_d <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[1:0], i_reset_pin_n};
      lpo_sync <= {lpo_sync[1:0], i_low_power_oscillator_clock};
      if (pin_sync[1] == pin_sync[2]) begin
        pin_level_n <= pin_sync[2];
      end
      if (lpo_sync[1] == lpo_sync[2]) begin
        lpo_level <= lpo_sync[2];
      end
      lpo_level_d <= lpo_level;
    end
  end

  wire lpo_tick = lpo_level & ~lpo_level_d;

  // ----------------------------------------------------------------
  // Glitch filters.
  // ----------------------------------------------------------------
  logic [5:0] bus_cnt;
  logic bus_out_n;
  logic [5:0] lpo_cnt;
  logic lpo_out_n;

  wire [1:0] rw_sel = filter_ctrl[`RW_SEL_HI:`RW_SEL_LO];
  wire stop_sel = filter_ctrl[`BIT_STOP_SEL];
  wire bus_en = ~i_stop_mode & (rw_sel == `RW_SEL_BUS);
  wire lpo_en = i_stop_mode ? stop_sel : (rw_sel == `RW_SEL_LPO);
  wire [5:0] bus_limit = {1'b0, filter_width} + 6'h01;
  wire [5:0] lpo_limit = 6'(LPO_COUNT);
  // Code 11 falls through to the unfiltered path.
  wire filt_n = bus_en ? bus_out_n :
                lpo_en ? lpo_out_n : pin_level_n;

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bus_cnt <= 6'h00;
      bus_out_n <= 1'b1;
    end else if (!bus_en) begin
      bus_cnt <= 6'h00;
      bus_out_n <= 1'b1;
    end else if (pin_level_n == bus_out_n) begin
      bus_cnt <= 6'h00;
    end else if (bus_cnt == bus_limit - 6'h01) begin
      bus_cnt <= 6'h00;
      bus_out_n <= pin_level_n;
    end else begin
      bus_cnt <= bus_cnt + 6'h01;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lpo_cnt <= 6'h00;
      lpo_out_n <= 1'b1;
    end else if (!lpo_en) begin
      lpo_cnt <= 6'h00;
      lpo_out_n <= 1'b1;
    end else if (pin_level_n == lpo_out_n) begin
      lpo_cnt <= 6'h00;
    end else if (lpo_tick) begin
      if (lpo_cnt == lpo_limit - 6'h01) begin
        lpo_cnt <= 6'h00;
        lpo_out_n <= pin_level_n;
      end else begin
        lpo_cnt <= lpo_cnt + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reset cause capture.
  // ----------------------------------------------------------------
  // Status lives on the power-on reset so that the cause survives the
  // system reset it triggers. Software writes never reach it.
  logic pin_reset_d;
  wire pin_event = o_pin_reset & ~pin_reset_d;
  wire clear_cause = i_low_voltage_detect | i_very_low_leakage_stop_wakeup |
                     pin_event;
  wire any_src = i_stop_ack_timeout | i_debugger_reset_req |
                 i_core_system_reset_request | i_core_lockup;
  // When two sources coincide only one is recorded, lockup first.
  wire [7:0] next_cause =
    i_core_lockup ? 8'(1) << `BIT_LOCKUP :
    i_core_system_reset_request ? 8'(1) << `BIT_SOFTWARE :
    i_debugger_reset_req ? 8'(1) << `BIT_DEBUGGER :
    8'(1) << `BIT_STOP_ACK;

  always_ff @(posedge i_clk_sys or posedge i_chip_por) begin
    if (i_chip_por) begin
      cause_status <= `CAUSE_RST;
    end else if (clear_cause) begin
      cause_status <= `CAUSE_RST;
    end else if (any_src) begin
      cause_status <= next_cause & `CAUSE_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts and reset request.
  // ----------------------------------------------------------------
  wire [7:0] irq_events = ((any_src ? next_cause : 8'h00) |
    (8'(pin_event) << `BIT_PIN_EVENT)) & `IRQ_MASK_BITS;
  // A source arriving during the clearing read is kept.
  wire [7:0] next_irq = (rd_irq ? 8'h00 : irq_status) | irq_events;

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_status <= `IRQ_RST;
      irq_mask <= `IRQ_RST;
      o_irq <= 1'b0;
      o_pin_reset <= 1'b0;
      pin_reset_d <= 1'b0;
      o_reset_req <= 1'b0;
    end else begin
      irq_status <= next_irq;
      if (wr_mask) begin
        irq_mask <= wr_data[7:0] & `IRQ_MASK_BITS;
      end
      o_irq <= |(next_irq & (wr_mask ? wr_data[7:0] : irq_mask));
      o_pin_reset <= ~filt_n;
      pin_reset_d <= o_pin_reset;
      o_reset_req <= any_src | ~filt_n;
    end
  end

endmodule

/* dv/rst_src_props.sv */
`timescale 1ns/1ns
module rst_src_props #(
  parameter int ADDR_W = 8,
  parameter int LPO_COUNT = 3
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_stop_ack_timeout,
  input wire logic i_debugger_reset_req,
  input wire logic i_core_system_reset_request,
  input wire logic i_core_lockup,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic o_reset_req,
  input wire logic o_irq
);
  // ----------------------------------------------------------------
  // Register reads, writes and reset sources.
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  wire logic rd_go = i_arvalid && o_arready;
  wire logic wr_go = i_awvalid && o_awready && i_wvalid && o_wready;
  wire logic any_src = i_stop_ack_timeout || i_debugger_reset_req ||
    i_core_system_reset_request || i_core_lockup;
  cause_zero_a: assert property (rd_go && i_araddr == 8'h04 |=>
    (o_rdata & 32'hffff_ffd1) == 32'h0000_0000) else $error("cause bits");
  cause_onehot_a: assert property (rd_go && i_araddr == 8'h04 |=>
    $onehot0(o_rdata[7:0])) else $error("cause not one-hot");
  ctrl_zero_a: assert property (rd_go && i_araddr == 8'h10 |=>
    o_rdata[31:3] == 0) else $error("control bits");
  width_zero_a: assert property (rd_go && i_araddr == 8'h14 |=>
    o_rdata[31:5] == 0) else $error("width bits");
  src_req_a: assert property (any_src |=> o_reset_req)
    else $error("reset request missing");
  unmapped_rd_a: assert property (rd_go && i_araddr == 8'h0c |=>
    o_rresp == 2'h2 && o_rdata == 0) else $error("unmapped read");
  rd_hold_a: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rdata)) else $error("read data dropped");
  wr_answer_a: assert property (wr_go |=> o_bvalid)
    else $error("write response late");
  bv_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("write response dropped");
  cover property (rd_go ##1 o_rvalid);
  cover property (wr_go ##1 o_bvalid);
  cover property ($rose(o_irq));
  cover property (o_rvalid && !i_rready ##1 o_rvalid);
endmodule

bind reset_source_status_and_pin_filter rst_src_props #(
  .ADDR_W(ADDR_W), .LPO_COUNT(LPO_COUNT)) u_rst_src_props (
  .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
  .i_stop_ack_timeout(i_stop_ack_timeout),
  .i_debugger_reset_req(i_debugger_reset_req),
  .i_core_system_reset_request(i_core_system_reset_request),
  .i_core_lockup(i_core_lockup), .i_awvalid(i_awvalid),
  .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
  .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr),
  .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
  .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
  .o_reset_req(o_reset_req), .o_irq(o_irq));

/* dv/lpo_model.sv */
`timescale 1ns/1ns
// The slow oscillator runs free; it is never stopped between events.
module lpo_model #(
  parameter int HALF = 4
) (
  input wire logic i_clk_sys,
  output logic o_lpo
);
  int cnt = 0;
  initial o_lpo = 1'b0;
  always @(posedge i_clk_sys) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) o_lpo <= ~o_lpo;
  end
endmodule

/* dv/tb.sv */
`timescale 1ns/1ns
module tb;
  typedef struct packed {logic [3:0] src; logic [31:0] exp;} row_s;
  logic clk = 0, rst = 1, por = 1, low_voltage_detect = 0, wak = 0, stp = 0, pin_n = 1;
  logic [3:0] src = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd_v;
  logic [1:0] rs_v;
  logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  wire logic awr, wr_r, bv, arr, rv, lpo, pin_rst, req, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int error_cnt = 0, check_count = 0;
  // Cycles the bus task waits before raising its response ready.
  int rdy_lag = 0;
  // Source order is stop ack, debugger, software, lockup.
  row_s rows [5] = '{'{4'h8, 32'h0000_0020}, '{4'h4, 32'h0000_0008},
    '{4'h2, 32'h0000_0004}, '{4'h1, 32'h0000_0002},
    '{4'h3, 32'h0000_0002}};
  reset_source_status_and_pin_filter u_reset_source_status_and_pin_filter (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_chip_por(por),
    .i_low_voltage_detect(low_voltage_detect), .i_very_low_leakage_stop_wakeup(wak),
    .i_stop_ack_timeout(src[3]), .i_debugger_reset_req(src[2]),
    .i_core_system_reset_request(src[1]), .i_core_lockup(src[0]),
    .i_stop_mode(stp), .i_reset_pin_n(pin_n),
    .i_low_power_oscillator_clock(lpo), .i_awaddr(awaddr),
    .i_awvalid(awv), .o_awready(awr), .i_wdata(wdata), .i_wstrb(4'hf),
    .i_wvalid(wv), .o_wready(wr_r), .o_bresp(bresp), .o_bvalid(bv),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arv),
    .o_arready(arr), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rv),
    .i_rready(rready), .o_pin_reset(pin_rst), .o_reset_req(req),
    .o_irq(irq));
  lpo_model u_lpo_model (.i_clk_sys(clk), .o_lpo(lpo));
  initial forever #50 clk = ~clk;
  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic results();
    $display("mismatches %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ta, tw, td;
    n = 0;
    @(posedge clk);
    if (w) begin
      awaddr <= a;
      wdata <= d;
      awv <= 1;
      wv <= 1;
      bready <= (rdy_lag == 0);
    end else begin
      araddr <= a;
      arv <= 1;
      rready <= (rdy_lag == 0);
    end
    do begin
      @(negedge clk);
      ta = w ? awv && awr : arv && arr;
      tw = wv && wr_r;
      td = w ? bv && bready : rv && rready;
      rd_v = rdata;
      rs_v = w ? bresp : rresp;
      @(posedge clk);
      if (ta && w) awv <= 0;
      if (ta && !w) arv <= 0;
      if (tw) wv <= 0;
      if (td && w) bready <= 0;
      if (td && !w) rready <= 0;
      if (n + 1 == rdy_lag && w) bready <= 1;
      if (n + 1 == rdy_lag && !w) rready <= 1;
      n++;
    end while (!td && n < 50);
    if (!td) begin
      error_cnt++;
      results();
    end
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, logic [31:0] e);
    bus(0, a, 32'h0000_0000);
    check(nm, rd_v, e);
  endtask
  task automatic do_rst(input logic p);
    @(posedge clk);
    rst <= 1;
    por <= p;
    repeat (2) @(posedge clk);
    rst <= 0;
    por <= 0;
  endtask
  // A short pulse that passes is seen within the window after release.
  task automatic pin(input int len, input logic e, input string nm);
    logic seen;
    seen = 0;
    @(posedge clk);
    pin_n <= 0;
    for (int i = 0; i < len + 120; i++) begin
      @(negedge clk);
      seen = seen | pin_rst;
      @(posedge clk);
      if (i == len - 1) pin_n <= 1;
    end
    check(nm, seen, e);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    por <= 0;
    foreach (rows[k]) begin
      @(posedge clk);
      src <= rows[k].src;
      @(posedge clk);
      src <= 0;
      rd_chk("cause", 8'h04, rows[k].exp);
    end
    bus(1, 8'h04, 32'hffff_ffff);
    check("cause_wr_resp", rs_v, 2'h0);
    rd_chk("cause_ro", 8'h04, 32'h0000_0002);
    low_voltage_detect <= 1;
    @(posedge clk);
    low_voltage_detect <= 0;
    rd_chk("cause_lvd", 8'h04, 32'h0000_0000);
    src <= 4'h4;
    @(posedge clk);
    src <= 0;
    wak <= 1;
    @(posedge clk);
    wak <= 0;
    rd_chk("cause_wake", 8'h04, 32'h0000_0000);
    rd_chk("unmapped", 8'h0c, 32'h0000_0000);
    check("unmapped_rresp", rs_v, 2'h2);
    bus(1, 8'h0c, 32'hffff_ffff);
    check("unmapped_bresp", rs_v, 2'h2);
    bus(1, 8'h10, 32'hffff_ffff);
    rd_chk("ctrl", 8'h10, 32'h0000_0007);
    bus(1, 8'h14, 32'hffff_ffff);
    rd_chk("width", 8'h14, 32'h0000_001f);
    do_rst(0);
    rd_chk("ctrl_keep", 8'h10, 32'h0000_0007);
    rd_chk("width_keep", 8'h14, 32'h0000_001f);
    do_rst(1);
    rd_chk("ctrl_por", 8'h10, 32'h0000_0000);
    rd_chk("width_por", 8'h14, 32'h0000_0000);
    rdy_lag = 3;
    bus(1, 8'h14, 32'h0000_0003);
    check("late_bready", rs_v, 2'h0);
    rd_chk("late_rready", 8'h14, 32'h0000_0003);
    rdy_lag = 0;
    bus(1, 8'h24, 32'h0000_0040);
    pin(3, 1, "pin_off");
    check("irq_on", irq, 1);
    rd_chk("irq_st", 8'h20, 32'h0000_0040);
    repeat (2) @(negedge clk);
    check("irq_off", irq, 0);
    bus(1, 8'h24, 32'h0000_0000);
    src <= 4'h1;
    @(posedge clk);
    src <= 0;
    repeat (3) @(negedge clk);
    check("irq_mask", irq, 0);
    bus(1, 8'h14, 32'h0000_0007);
    bus(1, 8'h10, 32'h0000_0001);
    pin(3, 0, "bus_short");
    pin(12, 1, "bus_long");
    bus(1, 8'h10, 32'h0000_0003);
    pin(3, 1, "rsv_code");
    bus(1, 8'h10, 32'h0000_0002);
    pin(3, 0, "lpo_short");
    pin(60, 1, "lpo_long");
    bus(1, 8'h10, 32'h0000_0001);
    stp <= 1;
    pin(3, 1, "stop_off");
    bus(1, 8'h10, 32'h0000_0005);
    pin(3, 0, "stop_short");
    pin(60, 1, "stop_long");
    bus(1, 8'h10, 32'h0000_0004);
    stp <= 0;
    results();
  end
endmodule
